// ===== hw/fac_host_port.sv
/*
 Host-facing interface of the float accelerator: strobe decode, operand
 and result handshakes, scratchpad mirrors, literal hold, status and
 maintenance registers, microbreak matching.
 Assumes the host drives all inputs synchronously to i_clk and marks T0.
*/
// Contract
// RL1: accelerator-enable clear forces every output off.
// RL2: error bit 31 set on any exception condition.
// RL3: reserved operand or overflow sets minus-zero bit and error bit.
// RL4: low four status bits return a fixed type code.
// RL5: strobe lines 71/70 decode nop, trap and host sync.
// RL6: both high decodes 57..55: 110 poly end, 111 diagnostic trap.
// RL7: host trap jumps to microaddress 0..7 from lines 57..55.
// RL8: vector 0 is power-up trap, vector 2 is abort trap.
// RL9: diagnostic trap branches to maintenance bits 23..16.
// RL10: both units run on 200 ns cycle with aligned start.
// RL11: opcode lines feed next microaddress generation.
// RL12: two mirror copies of sixteen host scratchpad registers.
// RL13: host writes mirrors in second half, device reads in first.
// RL14: device never writes its mirrors; results return on bus.
// RL15: operands taken off 32-bit operand bus; doubles take two.
// RL16: single and upper double literals latch into literal hold.
// RL17: result ready raises result sync; host takes it, gives sync.
// RL18: double second half held with result sync until host sync.
// RL19: condition codes N, V, Z from result; carry always clear.
// RL20: trap field writes need bit 31, microbreak writes need bit 15.
// RL21: bit 14 pulses when microaddress equals microbreak.
// RL22: current microaddress readable in maintenance bits 8..0.
// RL23: error output follows the accelerator-error status bit.
`timescale 1ns/1ps
module fac_host_port #(
    parameter logic [3:0] TYPE_CODE = fac_pkg::ST_TYPE_DEFAULT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_t0,
    // control strobe lines
    input wire logic [1:0] i_cs_hi,
    input wire logic [2:0] i_cs_lo,
    // opcode lines
    input wire logic [7:0] i_opcode_lines,
    // operand bus and register access
    input wire logic [31:0] i_operand_bus,
    input wire logic i_operand_literal,
    input wire logic i_reg_wr,
    input wire logic [4:0] i_reg_idx,
    output logic [31:0] o_reg_rdata,
    // scratchpad mirror writes from the addressing board
    input wire logic i_mirror_wr,
    input wire logic [3:0] i_mirror_addr,
    input wire logic [3:0] i_mirror_rd_addr,
    input wire logic [31:0] i_result_return_bus,
    // engine side
    input wire logic [8:0] i_engine_uaddr,
    input wire logic i_result_ready,
    input wire logic i_result_double,
    input wire logic [31:0] i_result_hi,
    input wire logic [31:0] i_result_lo,
    input wire logic i_exc_reserved,
    input wire logic i_exc_overflow,
    input wire logic i_exc_other,
    input wire logic i_drv_enable,
    // results to the host
    output logic [31:0] o_result_data,
    output logic o_result_oe,
    output logic o_result_sync,
    output logic [3:0] o_cond_codes,
    output logic o_accel_error_out,
    // to the engine
    output logic o_redirect,
    output logic [8:0] o_redirect_addr,
    output logic [7:0] o_opcode,
    output logic o_poly_end,
    output logic o_operand_valid,
    output logic [31:0] o_operand,
    output logic [31:0] o_literal,
    output logic [31:0] o_mirror_a,
    output logic [31:0] o_mirror_b,
    output logic o_match_pulse
);
    // ----------------------------------------
    // phase and mirrors
    // ----------------------------------------
    logic first_half;
    logic cycle_end;
    fac_mirror_if mif ();
    fac_phase u_phase (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_t0(i_t0),
        .o_first_half(first_half),
        .o_cycle_end(cycle_end)
    );
    fac_mirror #(.DEPTH(16)) u_mirror (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .m(mif)
    );
    assign mif.wr_en = i_mirror_wr && !first_half; // RL13
    assign mif.wr_addr = i_mirror_addr;
    assign mif.wr_data = i_result_return_bus; // RL12
    assign mif.rd_addr_a = i_mirror_rd_addr;
    assign mif.rd_addr_b = i_mirror_rd_addr;

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    logic status_en_reg;
    wire logic en = status_en_reg;
    wire logic host_sync_code = (i_cs_hi == fac_pkg::CS_SYNC); // RL5
    wire logic vectored_trap_request = (i_cs_hi == fac_pkg::CS_TRAP); // RL5
    wire logic cs_ext = (i_cs_hi == fac_pkg::CS_EXT);
    wire logic poly_end_req = cs_ext && i_cs_lo == fac_pkg::EXT_POLY_END;
    wire logic diagnostic_trap_request =
        cs_ext && i_cs_lo == fac_pkg::EXT_DIAG; // RL6

    // ----------------------------------------
    // status and maintenance registers
    // ----------------------------------------
    logic status_err_reg;
    logic status_mz_reg;
    logic [7:0] trap_addr_reg;
    logic [8:0] ubreak_reg;
    logic match_reg;
    wire logic wr_stat = i_reg_wr && i_reg_idx == fac_pkg::STAT_IDX;
    wire logic wr_maint = i_reg_wr && i_reg_idx == fac_pkg::MAINT_IDX;
    wire logic mz_event = i_exc_reserved || i_exc_overflow; // RL3
    wire logic err_event = mz_event || i_exc_other; // RL2
    wire logic match_now = (i_engine_uaddr == ubreak_reg); // RL21
    wire logic [31:0] stat_view = {status_err_reg, 3'h0, status_mz_reg,
        11'h000, status_en_reg, 11'h000, TYPE_CODE}; // RL4
    wire logic [31:0] maint_view = {1'b0, 7'h00, trap_addr_reg, 1'b0,
        match_reg, 5'h00, i_engine_uaddr}; // RL22
    wire logic [31:0] rdata_next =
        (i_reg_idx == fac_pkg::STAT_IDX) ? stat_view :
        (i_reg_idx == fac_pkg::MAINT_IDX) ? maint_view : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_en_reg <= fac_pkg::ST_EN_RESET;
            status_err_reg <= 1'b0;
            status_mz_reg <= 1'b0;
        end else begin
            if (wr_stat) status_en_reg <= i_operand_bus[fac_pkg::ST_EN_BIT];
            // error bits clear on a status write, but a new event wins
            if (err_event) status_err_reg <= 1'b1; // RL2
            else if (wr_stat) status_err_reg <= 1'b0;
            if (mz_event) status_mz_reg <= 1'b1; // RL3
            else if (wr_stat) status_mz_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            trap_addr_reg <= fac_pkg::MT_TRAP_RESET;
            ubreak_reg <= fac_pkg::MT_BRK_RESET;
            match_reg <= 1'b0;
        end else begin
            if (wr_maint && i_operand_bus[fac_pkg::MT_WTRAP_BIT])
                trap_addr_reg <= i_operand_bus[23:16]; // RL20
            if (wr_maint && i_operand_bus[fac_pkg::MT_WBRK_BIT])
                ubreak_reg <= i_operand_bus[8:0]; // RL20
            match_reg <= match_now; // RL21
        end
    end

    // ----------------------------------------
    // literal hold and operand capture
    // ----------------------------------------
    logic [31:0] literal_hold_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) literal_hold_reg <= 32'h0000_0000;
        else if (host_sync_code && i_operand_literal && en)
            literal_hold_reg <= i_operand_bus; // RL16
    end

    // ----------------------------------------
    // result return handshake
    // ----------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_HI = 2'b01,
        RS_LO = 2'b10
    } fac_rs_e;
    fac_rs_e rs_reg;
    fac_rs_e rs_next;
    logic [31:0] lo_hold_reg;
    always_comb begin
        rs_next = rs_reg;
        case (rs_reg)
            RS_IDLE: begin
                if (i_result_ready) rs_next = RS_HI; // RL17
            end
            RS_HI: begin
                if (host_sync_code)
                    rs_next = i_result_double ? RS_LO : RS_IDLE; // RL18
            end
            RS_LO: begin
                if (host_sync_code) rs_next = RS_IDLE; // RL18
            end
            default: rs_next = RS_IDLE;
        endcase
    end
    wire logic sending = (rs_next != RS_IDLE);
    wire logic [31:0] word_next = (rs_next == RS_LO) ? lo_hold_reg :
        i_result_hi;
    wire logic [3:0] cc_next = {word_next[31], i_exc_overflow,
        word_next == 32'h0000_0000, 1'b0}; // RL19

    // ----------------------------------------
    // redirects to the sequencer
    // ----------------------------------------
    wire logic [8:0] trap_vec = {6'h00, i_cs_lo}; // RL7 RL8
    wire logic [8:0] diag_vec = {1'b0, trap_addr_reg}; // RL9
    wire logic redirect_next = en &&
        (vectored_trap_request || diagnostic_trap_request);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rs_reg <= RS_IDLE;
            lo_hold_reg <= 32'h0000_0000;
            o_result_data <= 32'h0000_0000;
            o_result_oe <= 1'b0;
            o_result_sync <= 1'b0;
            o_cond_codes <= 4'h0;
            o_accel_error_out <= 1'b0;
            o_redirect <= 1'b0;
            o_redirect_addr <= 9'h000;
            o_opcode <= 8'h00;
            o_poly_end <= 1'b0;
            o_operand_valid <= 1'b0;
            o_operand <= 32'h0000_0000;
            o_literal <= 32'h0000_0000;
            o_mirror_a <= 32'h0000_0000;
            o_mirror_b <= 32'h0000_0000;
            o_match_pulse <= 1'b0;
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            rs_reg <= rs_next;
            if (rs_reg == RS_IDLE && i_result_ready)
                lo_hold_reg <= i_result_lo;
            o_result_sync <= en && sending; // RL1 RL17
            o_result_data <= en ? word_next : 32'h0000_0000; // RL1
            o_result_oe <= en && sending && i_drv_enable; // RL17
            o_cond_codes <= (en && sending) ? cc_next : 4'h0; // RL19
            o_accel_error_out <= en && status_err_reg; // RL23 RL1
            o_redirect <= redirect_next; // RL7 RL9
            o_redirect_addr <= !en ? 9'h000 :
                diagnostic_trap_request ? diag_vec : trap_vec; // RL1
            o_opcode <= en ? i_opcode_lines : 8'h00; // RL11
            o_poly_end <= en && poly_end_req; // RL6
            o_operand_valid <= en && host_sync_code &&
                rs_reg == RS_IDLE; // RL15
            if (!en) o_operand <= 32'h0000_0000; // RL1
            else if (host_sync_code) o_operand <= i_operand_bus; // RL15
            o_literal <= en ? literal_hold_reg : 32'h0000_0000; // RL16
            if (!en) begin
                o_mirror_a <= 32'h0000_0000; // RL1
                o_mirror_b <= 32'h0000_0000;
            end else if (first_half) begin
                o_mirror_a <= mif.rd_data_a; // RL13 RL14
                o_mirror_b <= mif.rd_data_b;
            end
            o_match_pulse <= en && match_now; // RL21
            o_reg_rdata <= en ? rdata_next : 32'h0000_0000; // RL1
        end
    end
endmodule : fac_host_port

// ===== hw/fac_mirror.sv
/*
 Two copies of the host scratchpad registers, written only by the host.
 Assumes the top gates writes to the second half of the cycle.
*/
`timescale 1ns/1ps
module fac_mirror #(
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    fac_mirror_if.store m
);
    initial begin
        if (DEPTH != 16) $error("fac_mirror: depth must be 16");
    end
    logic [31:0] copy_a_reg [DEPTH];
    logic [31:0] copy_b_reg [DEPTH];
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                copy_a_reg[i] <= 32'h0000_0000;
                copy_b_reg[i] <= 32'h0000_0000;
            end
        end else if (m.wr_en) begin
            copy_a_reg[m.wr_addr] <= m.wr_data; // RL12
            copy_b_reg[m.wr_addr] <= m.wr_data; // RL12
        end
    end
    assign m.rd_data_a = copy_a_reg[m.rd_addr_a];
    assign m.rd_data_b = copy_b_reg[m.rd_addr_b];
endmodule : fac_mirror

// ===== hw/fac_mirror_if.sv
/*
 Carrier between the top and the scratchpad mirror.
 Assumes one clock domain; write and read share no cycle phase.
*/
`timescale 1ns/1ps
interface fac_mirror_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] rd_addr_a;
    logic [3:0] rd_addr_b;
    logic [31:0] rd_data_a;
    logic [31:0] rd_data_b;
    modport owner (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                   input rd_data_a, rd_data_b);
    modport store (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                   output rd_data_a, rd_data_b);
endinterface : fac_mirror_if

// ===== hw/fac_phase.sv
/*
 Cycle phase counter: four clocks per 200 ns cycle, aligned to host T0.
 Assumes i_t0 pulses in the first clock of each host cycle.
*/
`timescale 1ns/1ps
module fac_phase (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_t0,
    output logic o_first_half,
    output logic o_cycle_end
);
    logic [1:0] ph_reg;
    logic [1:0] ph_next;
    assign ph_next = i_t0 ? 2'h1 : 2'(ph_reg + 2'h1);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) ph_reg <= 2'h0;
        else ph_reg <= ph_next; // RL10
    end
    assign o_first_half = (i_t0 || ph_reg == 2'h0 || ph_reg == 2'h1);
    assign o_cycle_end = (ph_reg == 2'(fac_pkg::CYCLE_CLKS - 1));
endmodule : fac_phase

// ===== hw/fac_pkg.sv
/*
 Shared constants for the accelerator host interface: register indexes,
 field positions, strobe codes, trap vectors and cycle timing.
 Assumes a single 20 MHz clock and a host-supplied phase marker.
*/
package fac_pkg;
    // ----------------------------------------
    // register indexes on the operand bus
    // ----------------------------------------
    localparam logic [4:0] MAINT_IDX = 5'h10;
    localparam logic [4:0] STAT_IDX = 5'h11;
    // ----------------------------------------
    // status fields
    // ----------------------------------------
    localparam int ST_ERR_BIT = 31;
    localparam int ST_MZ_BIT = 27;
    localparam int ST_EN_BIT = 15;
    localparam logic [3:0] ST_TYPE_DEFAULT = 4'h5; // arbitrary value
    localparam logic ST_EN_RESET = 1'b0;
    // ----------------------------------------
    // maintenance fields
    // ----------------------------------------
    localparam int MT_WTRAP_BIT = 31;
    localparam int MT_TRAP_HI = 23;
    localparam int MT_TRAP_LO = 16;
    localparam int MT_WBRK_BIT = 15;
    localparam int MT_MATCH_BIT = 14;
    localparam int UADDR_W = 9;
    localparam logic [7:0] MT_TRAP_RESET = 8'h00;
    localparam logic [8:0] MT_BRK_RESET = 9'h000;
    // ----------------------------------------
    // strobe codes, high line first
    // ----------------------------------------
    localparam logic [1:0] CS_NOP = 2'h0;
    localparam logic [1:0] CS_SYNC = 2'h1;
    localparam logic [1:0] CS_TRAP = 2'h2;
    localparam logic [1:0] CS_EXT = 2'h3;
    localparam logic [2:0] EXT_POLY_END = 3'h6;
    localparam logic [2:0] EXT_DIAG = 3'h7;
    localparam logic [8:0] TRAP_POWERUP = 9'h000;
    localparam logic [8:0] TRAP_ABORT = 9'h002;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int CYCLE_NS = 200;
    localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
endpackage : fac_pkg

// ===== tb/fac_host_model.sv
/*
 Host side of the result handshake: enables drivers, takes words.
 Assumes result data is valid while result sync stands.
*/
`timescale 1ns/1ps
module fac_host_model (
    // clock, reset, pacing
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_slow,
    // result return
    input wire logic i_result_sync,
    input wire logic [31:0] i_result_data,
    output logic o_drv_enable,
    output logic o_host_sync,
    // captured words
    output logic [3:0] o_count,
    output logic [31:0] o_prev,
    output logic [31:0] o_last
);
    logic [2:0] step_reg;
    wire [2:0] take_at = i_slow ? 3'h4 : 3'h1;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            step_reg <= 3'h0;
            o_drv_enable <= 1'b0;
            o_host_sync <= 1'b0;
            o_count <= 4'h0;
            o_prev <= 32'h0;
            o_last <= 32'h0;
        end else if (step_reg == 3'h0) begin
            step_reg <= {2'h0, i_result_sync};
            o_drv_enable <= i_result_sync;
        end else if (step_reg == take_at) begin
            o_prev <= o_last;
            o_last <= i_result_data;
            o_count <= o_count + 4'h1;
            o_host_sync <= 1'b1;
            step_reg <= step_reg + 3'h1;
        end else if (step_reg == take_at + 3'h2) begin
            o_drv_enable <= 1'b0;
            step_reg <= 3'h0;
        end else begin
            o_host_sync <= 1'b0;
            step_reg <= step_reg + 3'h1;
        end
    end
endmodule : fac_host_model

// ===== tb/fac_host_port_asserts.sv
/*
 Checker for the host port, bound to its top ports.
 Assumes one clock domain with async active-low reset.
*/
`timescale 1ns/1ps
module fac_host_port_asserts #(
    parameter logic [3:0] TYPE_CODE = 4'h5
) (
    // clock, reset, strobes and registers
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_cs_hi,
    input wire logic [2:0] i_cs_lo,
    input wire logic i_reg_wr,
    input wire logic [4:0] i_reg_idx,
    input wire logic [31:0] i_operand_bus,
    input wire logic [8:0] i_engine_uaddr,
    input wire logic i_exc_reserved,
    input wire logic i_exc_overflow,
    input wire logic i_exc_other,
    // observed outputs
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_result_sync,
    input wire logic o_result_oe,
    input wire logic [3:0] o_cond_codes,
    input wire logic o_accel_error_out,
    input wire logic o_redirect,
    input wire logic [8:0] o_redirect_addr,
    input wire logic o_poly_end,
    input wire logic o_match_pulse
);
    // ----------------------------------------
    // shadow of host-written fields
    // ----------------------------------------
    logic en_reg;
    logic [7:0] trap_reg;
    logic [8:0] brk_reg;
    wire st_wr = i_reg_wr && i_reg_idx == fac_pkg::STAT_IDX;
    wire mt_wr = i_reg_wr && i_reg_idx == fac_pkg::MAINT_IDX;
    wire ext = en_reg && i_cs_hi == fac_pkg::CS_EXT;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_reg <= 1'b0;
            trap_reg <= fac_pkg::MT_TRAP_RESET;
            brk_reg <= fac_pkg::MT_BRK_RESET;
        end else begin
            if (st_wr) en_reg <= i_operand_bus[15];
            if (mt_wr && i_operand_bus[31]) trap_reg <= i_operand_bus[23:16];
            if (mt_wr && i_operand_bus[15]) brk_reg <= i_operand_bus[8:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    off_quiet_a: assert property (!en_reg && !$past(en_reg) |->
        !o_redirect && !o_result_sync && !o_accel_error_out && !o_poly_end)
        else $error("output while disabled");
    trap_vector_a: assert property (en_reg && i_cs_hi == fac_pkg::CS_TRAP
        |=> o_redirect && o_redirect_addr == {6'h00, $past(i_cs_lo)})
        else $error("trap vector wrong");
    diag_trap_a: assert property (ext && i_cs_lo == fac_pkg::EXT_DIAG
        |=> o_redirect && o_redirect_addr == {1'b0, $past(trap_reg)})
        else $error("diagnostic trap address wrong");
    poly_end_a: assert property (ext && i_cs_lo == fac_pkg::EXT_POLY_END
        |=> o_poly_end) else $error("poly end missed");
    carry_clear_a: assert property (o_result_sync |-> !o_cond_codes[0])
        else $error("carry set");
    error_out_a: assert property (en_reg && (i_exc_reserved ||
        i_exc_overflow || i_exc_other) |-> ##[1:2] o_accel_error_out)
        else $error("error output missed");
    type_code_a: assert property (en_reg && $past(en_reg) &&
        $past(i_reg_idx) == fac_pkg::STAT_IDX |-> o_reg_rdata[3:0] == TYPE_CODE)
        else $error("type code wrong");
    micro_match_a: assert property (en_reg && i_engine_uaddr == brk_reg
        |=> o_match_pulse) else $error("match pulse missed");
    sync_hold_a: assert property (en_reg && o_result_sync &&
        i_cs_hi != fac_pkg::CS_SYNC |=> o_result_sync)
        else $error("result sync dropped early");
    oe_gated_a: assert property (o_result_oe |-> o_result_sync)
        else $error("drivers on without result sync");
    cover property (o_redirect);
    cover property (o_match_pulse);
    cover property (o_result_sync && i_cs_hi == fac_pkg::CS_SYNC);
endmodule : fac_host_port_asserts

bind fac_host_port fac_host_port_asserts #(.TYPE_CODE(TYPE_CODE)) u_chk (.*);

// ===== tb/fac_host_port_tb_top.sv
/*
 Self-checking bench for the host port with a host handshake model.
 Assumes 50 ns clock and four clocks per host cycle.
*/
`timescale 1ns/1ps
module fac_host_port_tb_top;
    typedef struct packed {
        logic [1:0] hi;
        logic [2:0] lo;
        logic red;
        logic [8:0] addr;
        logic poly;
        logic [7:0] opc;
    } fac_row_s;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_t0 = 1'b0, i_reg_wr = 1'b0;
    logic i_operand_literal = 1'b0, i_mirror_wr = 1'b0, i_result_ready = 1'b0;
    logic i_result_double = 1'b0, i_exc_reserved = 1'b0, slow = 1'b0;
    logic i_exc_overflow = 1'b0, i_exc_other = 1'b0, drv, hsync;
    logic [1:0] cs_hi = 2'h0, ph = 2'h0;
    logic [2:0] i_cs_lo = 3'h0;
    logic [3:0] i_mirror_addr = 4'h0, i_mirror_rd_addr = 4'h0, cnt;
    logic [4:0] i_reg_idx = 5'h00;
    logic [7:0] i_opcode_lines = 8'h00, o_opcode;
    logic [8:0] i_engine_uaddr = 9'h000, o_redirect_addr;
    logic [31:0] i_operand_bus = 32'h0, i_result_return_bus = 32'h0;
    logic [31:0] i_result_hi = 32'h0, i_result_lo = 32'h0, prev, last;
    logic [31:0] o_reg_rdata, o_result_data, o_operand, o_literal;
    logic [31:0] o_mirror_a, o_mirror_b;
    logic [3:0] o_cond_codes;
    logic o_result_oe, o_result_sync, o_accel_error_out, o_redirect;
    logic o_poly_end, o_operand_valid, o_match_pulse;
    wire [1:0] cs_w = hsync ? fac_pkg::CS_SYNC : cs_hi;
    int mismatches = 0, n_checks = 0, cyc = 0;
    fac_row_s rows [10];

    fac_host_port i_dut (.*, .i_cs_hi(cs_w), .i_drv_enable(drv));
    fac_host_model i_host (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_slow(slow), .i_result_sync(o_result_sync),
        .i_result_data(o_result_data), .o_drv_enable(drv),
        .o_host_sync(hsync), .o_count(cnt), .o_prev(prev), .o_last(last));

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ph <= ph + 2'h1;
        i_t0 <= (ph == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task pulse_cs(input logic [1:0] h, input logic [2:0] l);
        @(posedge i_clk);
        cs_hi <= h;
        i_cs_lo <= l;
        @(posedge i_clk);
        cs_hi <= 2'h0;
        #1;
    endtask : pulse_cs
    task wr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_idx <= idx;
        i_operand_bus <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] idx, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_clk);
        i_reg_idx <= idx;
        @(posedge i_clk);
        #1 chk(o_reg_rdata & m, e);
    endtask : rd
    task result(input logic dbl, input logic s, input logic [31:0] hi, lo);
        logic [3:0] n0;
        n0 = cnt;
        @(posedge i_clk);
        {slow, i_result_ready, i_result_double} <= {s, 1'b1, dbl};
        i_result_hi <= hi;
        i_result_lo <= lo;
        @(posedge i_clk);
        i_result_ready <= 1'b0;
        #1 chk(o_result_sync, 1'b1);
        chk(o_cond_codes[3], hi[31]);
        if (!dbl) chk(o_cond_codes[1], hi == 32'h0);
        for (int k = 0; k < 40 && cnt !== n0 + 4'h1 + dbl; k++) @(posedge i_clk);
        #1 chk(last, dbl ? lo : hi);
        if (dbl) chk(prev, hi);
    endtask : result
    task exc(input logic [2:0] e);
        wr(fac_pkg::STAT_IDX, 32'h0000_8000);
        @(posedge i_clk);
        {i_exc_reserved, i_exc_overflow, i_exc_other} <= e;
        @(posedge i_clk);
        {i_exc_reserved, i_exc_overflow, i_exc_other} <= 3'h0;
        @(posedge i_clk);
        #1 chk(o_accel_error_out, 1'b1);
        rd(fac_pkg::STAT_IDX, 32'h8800_0000, {1'b1, 3'h0, !e[0], 27'h0});
    endtask : exc
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            rows[i] = '{fac_pkg::CS_TRAP, 3'(i), 1'b1, 9'(i), 1'b0, 8'(17 * i)};
        end
        rows[8] = '{fac_pkg::CS_EXT, fac_pkg::EXT_POLY_END, 1'b0, 9'h000, 1'b1,
            8'hF0};
        rows[9] = '{fac_pkg::CS_NOP, 3'h5, 1'b0, 9'h000, 1'b0, 8'h0F};
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        pulse_cs(fac_pkg::CS_TRAP, 3'h2);
        chk(o_redirect, 1'b0);
        rd(fac_pkg::STAT_IDX, 32'hFFFF_FFFF, 32'h0);
        wr(fac_pkg::STAT_IDX, 32'h0000_8000);
        rd(fac_pkg::STAT_IDX, 32'hFFFF_FFFF,
            32'h0000_8000 | 32'(fac_pkg::ST_TYPE_DEFAULT));
        foreach (rows[i]) begin
            @(posedge i_clk);
            i_opcode_lines <= rows[i].opc;
            pulse_cs(rows[i].hi, rows[i].lo);
            chk(o_redirect, rows[i].red);
            if (rows[i].red) chk(o_redirect_addr, rows[i].addr);
            chk(o_poly_end, rows[i].poly);
            chk(o_opcode, rows[i].opc);
        end
        wr(fac_pkg::MAINT_IDX, 32'h0034_0000);
        pulse_cs(fac_pkg::CS_EXT, fac_pkg::EXT_DIAG);
        chk(o_redirect_addr, {1'b0, fac_pkg::MT_TRAP_RESET});
        wr(fac_pkg::MAINT_IDX, 32'h8034_0000);
        pulse_cs(fac_pkg::CS_EXT, fac_pkg::EXT_DIAG);
        chk(o_redirect_addr, 9'h034);
        @(posedge i_clk);
        i_engine_uaddr <= 9'h054;
        wr(fac_pkg::MAINT_IDX, 32'h0000_8055);
        rd(fac_pkg::MAINT_IDX, 32'h00FF_41FF, 32'h0034_0054);
        @(posedge i_clk);
        i_engine_uaddr <= 9'h055;
        @(posedge i_clk);
        #1 chk(o_match_pulse, 1'b1);
        @(posedge i_clk iff ph == 2'h1);
        i_mirror_wr <= 1'b1;
        i_mirror_addr <= 4'h3;
        i_result_return_bus <= 32'h5A5A_00C3;
        @(posedge i_clk);
        i_mirror_wr <= 1'b0;
        i_mirror_rd_addr <= 4'h3;
        repeat (8) @(posedge i_clk);
        #1 chk(o_mirror_a, 32'h5A5A_00C3);
        chk(o_mirror_b, 32'h5A5A_00C3);
        @(posedge i_clk);
        i_operand_bus <= 32'h1234_5678;
        pulse_cs(fac_pkg::CS_SYNC, 3'h0);
        chk(o_operand_valid, 1'b1);
        chk(o_operand, 32'h1234_5678);
        @(posedge i_clk);
        i_operand_literal <= 1'b1;
        i_operand_bus <= 32'hC0DE_0042;
        pulse_cs(fac_pkg::CS_SYNC, 3'h0);
        @(posedge i_clk);
        i_operand_literal <= 1'b0;
        #1 chk(o_literal, 32'hC0DE_0042);
        result(1'b1, 1'b1, 32'h8000_0001, 32'h0000_00F0);
        result(1'b0, 1'b0, 32'h0, 32'h0);
        exc(3'h4);
        exc(3'h2);
        exc(3'h1);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        #1 chk(o_accel_error_out, 1'b0);
        rd(fac_pkg::STAT_IDX, 32'hFFFF_FFFF, 32'h0);
        end_of_test();
    end
endmodule : fac_host_port_tb_top
